// ---- sffe_pkg.sv ----
// Package: constants and types of the frame forwarding engine and its pipe
// Operation
// (RULE1) Stage receive bytes in blocks up to 128
// (RULE2) Request memory bus, copy only after grant
// (RULE3) Round-robin service of port bus requests
// (RULE4) Switch request only after whole frame stored
// (RULE5) Take cast, port, device from response
// (RULE6) Local destination: enqueue job at that port
// (RULE7) Remote destination: offer message, partner enqueues job
// (RULE8) Take job only with max-frame room, frame ended
// (RULE9) Four FIFO priority queues per port; partner engine keeps one shared job FIFO and ignores priority
// (RULE10) Local transmit in granules up to 128 bytes
// (RULE11) Partner fetches; source sends 128-byte granules
// (RULE12) Remote unicast granules go straight to transmit
// (RULE13) Remote multicast stored once, then jobs enqueued
// (RULE14) Multicast: one job per local port
// (RULE15) Copy counter per frame; release at zero
// (RULE16) Unresolved lookup goes to helper processor
// (RULE17) Unknown destination floods source VLAN ports
// (RULE18) Host unicast control frame: buffer, then helper
// (RULE19) Host multicast control frame: buffer, then helper
// (RULE20) Last granule marked as frame end
package sffe_pkg;
   localparam int NPORT = 12;
   localparam int NPRI = 4;
   localparam int QDEPTH = 4;
   localparam int QW = $clog2(QDEPTH);
   localparam int NHANDLE = 16;
   localparam int BLK_BYTES = 128;
   localparam int MAX_FRAME = 1536;
   localparam int PW = 4;
   localparam int HW = 4;
   localparam int LW = 11;
   localparam int BW = 8;
   localparam int CW = 5;
   typedef logic [PW-1:0] sffe_port_type;
   typedef logic [HW-1:0] sffe_handle_type;
   typedef logic [LW-1:0] sffe_len_type;
   typedef logic [NPORT-1:0] sffe_mask_type;
   typedef struct packed {
      sffe_handle_type handle;
      logic multi;
      sffe_port_type port;
      logic [1:0] pri;
      sffe_mask_type mask;
   } sffe_offer_type;
endpackage

// ---- sffe_pipe_if.sv ----
// Interface: chip_to_chip_pipe between source engine and partner engine
`timescale 1ns/1ps
interface sffe_pipe_if (
   input wire logic mclk,
   input wire logic rst_n
);
   import sffe_pkg::*;
   logic offer_v;
   sffe_offer_type offer;
   logic fetch_v;
   sffe_handle_type fetch_handle;
   logic gran_v;
   sffe_handle_type gran_handle;
   logic [BW-1:0] gran_len;
   logic gran_last;
   modport src (input mclk, rst_n, fetch_v, fetch_handle,
      output offer_v, offer, gran_v, gran_handle, gran_len, gran_last);
   modport dst (input mclk, rst_n, offer_v, offer, gran_v, gran_handle, gran_len, gran_last,
      output fetch_v, fetch_handle);
endinterface

// ---- sffe_local.sv ----
// Module: source-side frame forwarding engine
`timescale 1ns/1ps
module sffe_local (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [sffe_pkg::NPORT-1:0] rx_v,
   input wire logic [sffe_pkg::NPORT-1:0] rx_eof,
   output logic [sffe_pkg::NPORT-1:0] rx_hold,
   output logic mem_req,
   input wire logic mem_gnt,
   output sffe_pkg::sffe_port_type mem_port,
   output logic [sffe_pkg::BW-1:0] mem_len,
   output sffe_pkg::sffe_handle_type mem_handle,
   output logic sw_req_v,
   output sffe_pkg::sffe_handle_type sw_req_handle,
   output sffe_pkg::sffe_port_type sw_req_port,
   input wire logic sw_rsp_v,
   input wire sffe_pkg::sffe_handle_type sw_rsp_handle,
   input wire logic sw_rsp_multi,
   input wire logic sw_rsp_remote,
   input wire logic sw_rsp_unres,
   input wire logic sw_rsp_unknown,
   input wire sffe_pkg::sffe_port_type sw_rsp_port,
   input wire logic [1:0] sw_rsp_pri,
   input wire sffe_pkg::sffe_mask_type sw_rsp_lmask,
   input wire sffe_pkg::sffe_mask_type sw_rsp_rmask,
   input wire sffe_pkg::sffe_mask_type sw_rsp_vlan,
   input wire logic [sffe_pkg::CW-1:0] sw_rsp_copies,
   output logic helper_v,
   output sffe_pkg::sffe_handle_type helper_handle,
   input wire logic [sffe_pkg::NPORT-1:0][sffe_pkg::LW-1:0] tx_free,
   output logic tx_v,
   output sffe_pkg::sffe_port_type tx_port,
   output logic [sffe_pkg::BW-1:0] tx_len,
   output logic tx_last,
   output logic rel_v,
   output sffe_pkg::sffe_handle_type rel_handle,
   sffe_pipe_if.src pipe
);
   import sffe_pkg::*;
   localparam int NQ = NPORT * NPRI;
   typedef enum logic [1:0] {T_IDLE = 2'b00, T_LOCAL = 2'b01, T_PIPE = 2'b10} sffe_tx_type;

   function automatic logic [PW:0] rr_pick(input logic [NPORT-1:0] req, input sffe_port_type last);
      logic [PW:0] r;
      int k;
      r = '0;
      for (int i = NPORT; i >= 1; i--) begin
         k = (int'(last) + i) % NPORT;
         if (req[k]) begin
            r = {1'b1, PW'(k)};
         end
      end
      return r;
   endfunction

   logic [BW-1:0] scnt [NPORT];
   logic seof [NPORT];
   logic [NPORT-1:0] gnt_clr;
   logic [PW:0] rx_pick;
   sffe_port_type rr_last;
   sffe_handle_type ph [NPORT];
   logic [NPORT-1:0] pstart;
   sffe_handle_type alloc;
   logic mem_eof;
   logic mem_first;
   sffe_len_type flen [NHANDLE];
   logic [CW-1:0] cnt [NHANDLE];
   logic enq_v;
   logic [1:0] enq_pri;
   sffe_handle_type enq_h;
   sffe_mask_type enq_mask;
   logic [NQ-1:0] sq_ne;
   sffe_handle_type sq_head [NQ];
   logic [NPORT-1:0] port_ok;
   logic [PW:0] tx_pick;
   sffe_port_type tx_rr;
   logic pop_v;
   logic [$clog2(NQ)-1:0] pop_q;
   sffe_tx_type tstate;
   sffe_handle_type cur_h;
   sffe_len_type rem;
   logic fetch_pend;
   sffe_handle_type fetch_h;
   logic fetch_take;
   logic dec_v;
   logic [BW-1:0] glen;

   // Staging holds counts only; payload travels with the memory bus copy
   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_rx
         logic hold;
         assign rx_hold[g] = hold;
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               scnt[g] <= '0;
               seof[g] <= 1'b0;
               hold <= 1'b0;
            end else if (gnt_clr[g]) begin
               scnt[g] <= '0;
               seof[g] <= 1'b0;
               hold <= 1'b0;
            end else if (rx_v[g] && !hold) begin
               scnt[g] <= scnt[g] + 1'b1;
               seof[g] <= rx_eof[g];
               hold <= rx_eof[g] || (scnt[g] == BW'(BLK_BYTES - 1)); // RULE1
            end
         end
      end
   endgenerate

   assign rx_pick = rr_pick(rx_hold, rr_last); // RULE3
   assign gnt_clr = (mem_req && mem_gnt) ? (NPORT'(1) << mem_port) : '0; // RULE2

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req <= 1'b0;
         mem_port <= '0;
         mem_len <= '0;
         mem_handle <= '0;
         mem_eof <= 1'b0;
         mem_first <= 1'b0;
         rr_last <= PW'(NPORT - 1);
         pstart <= '1;
         alloc <= '0;
         sw_req_v <= 1'b0;
         sw_req_handle <= '0;
         sw_req_port <= '0;
      end else begin
         sw_req_v <= 1'b0;
         if (!mem_req && rx_pick[PW]) begin
            mem_req <= 1'b1; // RULE2
            mem_port <= rx_pick[PW-1:0];
            mem_len <= scnt[rx_pick[PW-1:0]];
            mem_eof <= seof[rx_pick[PW-1:0]];
            mem_first <= pstart[rx_pick[PW-1:0]];
            mem_handle <= pstart[rx_pick[PW-1:0]] ? alloc : ph[rx_pick[PW-1:0]];
            if (pstart[rx_pick[PW-1:0]]) begin
               ph[rx_pick[PW-1:0]] <= alloc;
               alloc <= alloc + 1'b1;
               pstart[rx_pick[PW-1:0]] <= 1'b0;
            end
         end else if (mem_req && mem_gnt) begin
            mem_req <= 1'b0;
            rr_last <= mem_port; // RULE3
            if (mem_eof) begin
               pstart[mem_port] <= 1'b1;
               sw_req_v <= 1'b1; // RULE4
               sw_req_handle <= mem_handle;
               sw_req_port <= mem_port;
            end
         end
      end
   end

   // Frame length grows block by block as each block is granted
   always_ff @(posedge mclk) begin
      if (mem_req && mem_gnt) begin
         flen[mem_handle] <= (mem_first ? '0 : flen[mem_handle]) + LW'(mem_len);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enq_v <= 1'b0;
         enq_pri <= '0;
         enq_h <= '0;
         enq_mask <= '0;
         helper_v <= 1'b0;
         helper_handle <= '0;
         pipe.offer_v <= 1'b0;
         pipe.offer <= '0;
      end else begin
         enq_v <= 1'b0;
         helper_v <= 1'b0;
         pipe.offer_v <= 1'b0;
         if (sw_rsp_v && sw_rsp_unres) begin
            helper_v <= 1'b1; // RULE16
            helper_handle <= sw_rsp_handle;
         end else if (sw_rsp_v) begin
            enq_v <= 1'b1; // RULE5
            enq_pri <= sw_rsp_pri;
            enq_h <= sw_rsp_handle;
            if (sw_rsp_unknown) begin
               enq_mask <= sw_rsp_vlan; // RULE17
            end else if (sw_rsp_multi) begin
               enq_mask <= sw_rsp_lmask; // RULE14
            end else if (sw_rsp_remote) begin
               enq_mask <= '0;
            end else begin
               enq_mask <= NPORT'(1) << sw_rsp_port; // RULE6
            end
            if (!sw_rsp_unknown && (sw_rsp_multi ? |sw_rsp_rmask : sw_rsp_remote)) begin
               pipe.offer_v <= 1'b1; // RULE7 RULE13
               pipe.offer <= {sw_rsp_handle, sw_rsp_multi, sw_rsp_port, sw_rsp_pri, sw_rsp_rmask};
            end
         end
      end
   end

   generate
      for (g = 0; g < NQ; g++) begin : g_sq
         sffe_handle_type mem [QDEPTH];
         logic [QW-1:0] wp;
         logic [QW-1:0] rp;
         logic [QW:0] n;
         logic push;
         logic pop;
         assign push = enq_v && enq_mask[g / NPRI] && (enq_pri == 2'(g % NPRI)) && (n != (QW+1)'(QDEPTH));
         assign pop = pop_v && (pop_q == ($clog2(NQ))'(g));
         assign sq_ne[g] = (n != '0);
         assign sq_head[g] = mem[rp]; // RULE9
         always_ff @(posedge mclk) begin
            if (push) begin
               mem[wp] <= enq_h;
            end
         end
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               wp <= '0;
               rp <= '0;
               n <= '0;
            end else begin
               wp <= wp + QW'(push);
               rp <= rp + QW'(pop);
               n <= n + (QW+1)'(push) - (QW+1)'(pop);
            end
         end
      end
      for (g = 0; g < NPORT; g++) begin : g_port
         assign port_ok[g] = (|sq_ne[g*NPRI +: NPRI]) && (tx_free[g] >= LW'(MAX_FRAME)); // RULE8
      end
   endgenerate

   // One mover serves every port, so a port never has two frames in flight
   assign tx_pick = rr_pick(port_ok, tx_rr);
   assign pop_v = (tstate == T_IDLE) && !fetch_pend && tx_pick[PW]; // RULE8
   assign fetch_take = (tstate == T_IDLE) && fetch_pend;
   assign glen = (rem > LW'(BLK_BYTES)) ? BW'(BLK_BYTES) : BW'(rem);
   assign dec_v = (tstate != T_IDLE) && (rem <= LW'(BLK_BYTES));

   always_comb begin
      pop_q = '0;
      for (int i = 0; i < NPRI; i++) begin
         if (sq_ne[int'(tx_pick[PW-1:0]) * NPRI + i]) begin
            pop_q = ($clog2(NQ))'(int'(tx_pick[PW-1:0]) * NPRI + i);
         end
      end
   end

   // Set wins over the take
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_pend <= 1'b0;
         fetch_h <= '0;
      end else if (pipe.fetch_v) begin
         fetch_pend <= 1'b1; // RULE11
         fetch_h <= pipe.fetch_handle;
      end else if (fetch_take) begin
         fetch_pend <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tstate <= T_IDLE;
         cur_h <= '0;
         rem <= '0;
         tx_rr <= PW'(NPORT - 1);
         tx_v <= 1'b0;
         tx_port <= '0;
         tx_len <= '0;
         tx_last <= 1'b0;
         pipe.gran_v <= 1'b0;
         pipe.gran_handle <= '0;
         pipe.gran_len <= '0;
         pipe.gran_last <= 1'b0;
      end else begin
         tx_v <= 1'b0;
         pipe.gran_v <= 1'b0;
         unique case (tstate)
            T_IDLE: begin
               if (fetch_take) begin
                  cur_h <= fetch_h;
                  rem <= flen[fetch_h];
                  tstate <= T_PIPE;
               end else if (pop_v) begin
                  cur_h <= sq_head[pop_q];
                  rem <= flen[sq_head[pop_q]];
                  tx_port <= tx_pick[PW-1:0];
                  tx_rr <= tx_pick[PW-1:0];
                  tstate <= T_LOCAL;
               end
            end
            T_LOCAL: begin
               tx_v <= 1'b1; // RULE10
               tx_len <= glen;
               tx_last <= dec_v; // RULE20
               rem <= rem - LW'(glen);
               if (dec_v) begin
                  tstate <= T_IDLE;
               end
            end
            T_PIPE: begin
               pipe.gran_v <= 1'b1; // RULE11
               pipe.gran_handle <= cur_h;
               pipe.gran_len <= glen;
               pipe.gran_last <= dec_v; // RULE20
               rem <= rem - LW'(glen);
               if (dec_v) begin
                  tstate <= T_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rel_v <= 1'b0;
         rel_handle <= '0;
      end else begin
         rel_v <= dec_v && (cnt[cur_h] == CW'(1)); // RULE15
         rel_handle <= cur_h;
      end
   end

   always_ff @(posedge mclk) begin
      if (dec_v) begin
         cnt[cur_h] <= cnt[cur_h] - 1'b1; // RULE15
      end
      if (sw_rsp_v && !sw_rsp_unres) begin
         cnt[sw_rsp_handle] <= sw_rsp_copies;
      end
   end
endmodule

// ---- sffe_remote.sv ----
// Module: partner-side engine serving offers arriving over the pipe
`timescale 1ns/1ps
module sffe_remote (
   input wire logic mclk,
   input wire logic rst_n,
   sffe_pipe_if.dst pipe,
   input wire logic [sffe_pkg::NPORT-1:0][sffe_pkg::LW-1:0] tx_free,
   output logic tx_v,
   output sffe_pkg::sffe_port_type tx_port,
   output logic [sffe_pkg::BW-1:0] tx_len,
   output logic tx_last,
   output logic buf_wr_v,
   output logic [sffe_pkg::BW-1:0] buf_wr_len,
   output logic rel_v
);
   import sffe_pkg::*;
   typedef enum logic [2:0] {R_IDLE = 3'b000, R_WAIT = 3'b001, R_STORE = 3'b010, R_SEND = 3'b011,
      R_COPY = 3'b100} sffe_rstate_type;

   sffe_offer_type jq [QDEPTH];
   logic [QW-1:0] wp;
   logic [QW-1:0] rp;
   logic [QW:0] n;
   logic push;
   logic pop;
   sffe_offer_type head;
   sffe_rstate_type st;
   sffe_mask_type mmask;
   sffe_len_type mlen;
   sffe_len_type rem;
   logic [PW:0] low;
   logic [BW-1:0] glen;

   // Offers beyond the queue depth are dropped
   assign push = pipe.offer_v && (n != (QW+1)'(QDEPTH));
   assign head = jq[rp];
   assign pop = (st == R_IDLE) && (n != '0) && (head.multi || tx_free[head.port] >= LW'(MAX_FRAME));
   assign glen = (rem > LW'(BLK_BYTES)) ? BW'(BLK_BYTES) : BW'(rem);

   always_comb begin
      low = '0;
      for (int i = NPORT - 1; i >= 0; i--) begin
         if (mmask[i]) begin
            low = {1'b1, PW'(i)};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         jq[wp] <= pipe.offer; // RULE7
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
         n <= '0;
      end else begin
         wp <= wp + QW'(push);
         rp <= rp + QW'(pop);
         n <= n + (QW+1)'(push) - (QW+1)'(pop);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= R_IDLE;
         pipe.fetch_v <= 1'b0;
         pipe.fetch_handle <= '0;
         tx_v <= 1'b0;
         tx_port <= '0;
         tx_len <= '0;
         tx_last <= 1'b0;
         buf_wr_v <= 1'b0;
         buf_wr_len <= '0;
         rel_v <= 1'b0;
         mmask <= '0;
         mlen <= '0;
         rem <= '0;
      end else begin
         pipe.fetch_v <= 1'b0;
         tx_v <= 1'b0;
         buf_wr_v <= 1'b0;
         rel_v <= 1'b0;
         unique case (st)
            R_IDLE: begin
               if (pop) begin
                  pipe.fetch_v <= 1'b1; // RULE11
                  pipe.fetch_handle <= head.handle;
                  tx_port <= head.port;
                  mmask <= head.mask;
                  mlen <= '0;
                  st <= head.multi ? R_STORE : R_WAIT;
               end
            end
            R_WAIT: begin
               if (pipe.gran_v) begin
                  tx_v <= 1'b1; // RULE12
                  tx_len <= pipe.gran_len;
                  tx_last <= pipe.gran_last;
                  if (pipe.gran_last) begin
                     st <= R_IDLE;
                  end
               end
            end
            R_STORE: begin
               if (pipe.gran_v) begin
                  buf_wr_v <= 1'b1; // RULE13
                  buf_wr_len <= pipe.gran_len;
                  mlen <= mlen + LW'(pipe.gran_len);
                  if (pipe.gran_last) begin
                     st <= R_SEND;
                  end
               end
            end
            R_SEND: begin
               // Jobs are only taken after the whole copy is stored
               if (!low[PW]) begin
                  rel_v <= 1'b1;
                  st <= R_IDLE;
               end else if (tx_free[low[PW-1:0]] >= LW'(MAX_FRAME)) begin
                  tx_port <= low[PW-1:0];
                  mmask[low[PW-1:0]] <= 1'b0; // RULE13
                  rem <= mlen;
                  st <= R_COPY;
               end
            end
            R_COPY: begin
               tx_v <= 1'b1;
               tx_len <= glen;
               tx_last <= (rem <= LW'(BLK_BYTES));
               rem <= rem - LW'(glen);
               if (rem <= LW'(BLK_BYTES)) begin
                  st <= R_SEND;
               end
            end
            default: begin
               st <= R_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- sffe_pipe_chk.sv ----
// Checker: timing and framing assertions on the chip-to-chip pipe
`timescale 1ns/1ps
module sffe_pipe_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic offer_v,
   input wire sffe_pkg::sffe_offer_type offer,
   input wire logic fetch_v,
   input wire sffe_pkg::sffe_handle_type fetch_handle,
   input wire logic gran_v,
   input wire sffe_pkg::sffe_handle_type gran_handle,
   input wire logic [sffe_pkg::BW-1:0] gran_len,
   input wire logic gran_last
);
   import sffe_pkg::*;
   logic [NHANDLE-1:0] offered;
   logic [3:0] gcnt;
   int pend;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Offered handles; a wrapped handle reuse is not told apart
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         offered <= '0;
      end else begin
         if (offer_v) begin
            offered[offer.handle] <= 1'b1;
         end
         if (fetch_v) begin
            offered[fetch_handle] <= 1'b0;
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gcnt <= 4'h0;
      end else if (gran_v) begin
         gcnt <= gran_last ? 4'h0 : gcnt + 4'h1;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 0;
      end else begin
         pend <= pend + int'(fetch_v) - int'(gran_v && gran_last);
      end
   end
   a_gran_len_range: assert property (gran_v |-> gran_len >= 8'h01 && gran_len <= 8'h80)
      else $error("granule length out of range");
   a_gran_full_size: assert property (gran_v && !gran_last |-> gran_len == 8'h80)
      else $error("short granule before frame end");
   a_gran_back_to_back: assert property (gran_v && !gran_last |=> gran_v)
      else $error("gap inside granule burst");
   a_gran_same_handle: assert property (gran_v && !gran_last |=> gran_handle == $past(gran_handle))
      else $error("handle changed inside frame");
   a_fetch_then_frame: assert property (fetch_v |-> ##[2:400] (gran_v && gran_last))
      else $error("fetch not answered by a frame");
   a_fetch_was_offered: assert property (fetch_v |-> offered[fetch_handle])
      else $error("fetch without offer");
   a_gran_needs_fetch: assert property (gran_v |-> pend > 0)
      else $error("granule without fetch");
   a_offer_multi_mask: assert property (offer_v && offer.multi |-> offer.mask != '0)
      else $error("multicast offer with empty mask");
   a_frame_max_count: assert property (gran_v |-> int'(gcnt) < MAX_FRAME / BLK_BYTES)
      else $error("too many granules in frame");
endmodule

// ---- tb.sv ----
// Testbench: both engines across the pipe against a byte-count model
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %0d want %0d", $time, a, b); end end
module tb;
   import sffe_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, mem_gnt = 1'b0, rsp_v = 1'b0, multi = 1'b0, remote = 1'b0, unres = 1'b0, unknown = 1'b0;
   logic [NPORT-1:0] rx_v = '0, rx_eof = '0, rx_hold, lm = '0, rm = '0, vm = '0, ma, mb;
   logic [NPORT-1:0][LW-1:0] tx_free, r_free;
   logic mem_req, sw_req_v, helper_v, tx_v, tx_last, rel_v, r_tx_v, r_tx_last, buf_wr_v, r_rel_v;
   sffe_port_type mem_port, sw_req_port, tx_port, r_tx_port, dp = '0;
   sffe_handle_type sw_req_handle, helper_handle, rel_handle, sh = '0, lastrel, lasthelp, mem_handle;
   logic [BW-1:0] mem_len, tx_len, r_tx_len, buf_wr_len;
   logic [1:0] pri = 2'h0;
   logic [CW-1:0] cps = '0;
   int bad_count = 0, tests_run = 0, cyc = 0, idle = 0, seed = 71, gseed = 71, lastp = 0, k, n, src, lp, nfr = 0;
   int rem[NPORT], gb[NPORT], expn[NPORT], lb[NPORT], rb[NPORT], el[NPORT], er[NPORT], run[NPORT];
   int nrel = 0, nrrel = 0, nbuf = 0, nhelp = 0, erel = 0, errel = 0, ebuf = 0, ehelp = 0;
   sffe_handle_type hnd[NPORT];
   int gq[$], fq[$], xq[$];
   sffe_pipe_if pipe (.mclk(mclk), .rst_n(rst_n));
   sffe_local i_sffe_local (.mclk(mclk), .rst_n(rst_n), .rx_v(rx_v), .rx_eof(rx_eof), .rx_hold(rx_hold),
      .mem_req(mem_req), .mem_gnt(mem_gnt), .mem_port(mem_port), .mem_len(mem_len), .mem_handle(mem_handle),
      .sw_req_v(sw_req_v), .sw_req_handle(sw_req_handle), .sw_req_port(sw_req_port), .sw_rsp_v(rsp_v),
      .sw_rsp_handle(sh), .sw_rsp_multi(multi), .sw_rsp_remote(remote), .sw_rsp_unres(unres),
      .sw_rsp_unknown(unknown), .sw_rsp_port(dp), .sw_rsp_pri(pri), .sw_rsp_lmask(lm), .sw_rsp_rmask(rm),
      .sw_rsp_vlan(vm), .sw_rsp_copies(cps), .helper_v(helper_v), .helper_handle(helper_handle),
      .tx_free(tx_free), .tx_v(tx_v), .tx_port(tx_port), .tx_len(tx_len), .tx_last(tx_last), .rel_v(rel_v),
      .rel_handle(rel_handle), .pipe(pipe));
   sffe_remote i_sffe_remote (.mclk(mclk), .rst_n(rst_n), .pipe(pipe), .tx_free(r_free), .tx_v(r_tx_v),
      .tx_port(r_tx_port), .tx_len(r_tx_len), .tx_last(r_tx_last), .buf_wr_v(buf_wr_v),
      .buf_wr_len(buf_wr_len), .rel_v(r_rel_v));
   sffe_pipe_chk i_sffe_pipe_chk (.mclk(mclk), .rst_n(rst_n), .offer_v(pipe.offer_v), .offer(pipe.offer),
      .fetch_v(pipe.fetch_v), .fetch_handle(pipe.fetch_handle), .gran_v(pipe.gran_v),
      .gran_handle(pipe.gran_handle), .gran_len(pipe.gran_len), .gran_last(pipe.gran_last));
   function automatic int lfsr(input int s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int rnd(input int m);
      seed = lfsr(seed);
      return seed % m;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always #4 mclk = ~mclk;
   // Random grant delay keeps requests standing for several cycles
   always @(negedge mclk) begin
      gseed = lfsr(gseed);
      mem_gnt <= mem_req & gseed[0];
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         summarize();
      end
   end
   always @(posedge mclk) if (rst_n) begin
      idle = (tx_v | r_tx_v | buf_wr_v | pipe.gran_v | pipe.offer_v | pipe.fetch_v | mem_req) ? 0 : idle + 1;
      if (mem_req && mem_gnt) begin
         `CHK(mem_len, (rem[mem_port] > 128) ? 128 : rem[mem_port])
         `CHK(mem_handle, sffe_handle_type'(nfr))
         gq.push_back(int'(mem_port));
         lastp = mem_port;
         gb[mem_port] += mem_len;
         rem[mem_port] -= mem_len;
      end
      if (sw_req_v) begin
         `CHK(gb[sw_req_port], expn[sw_req_port])
         hnd[sw_req_port] = sffe_handle_type'(nfr++);
         `CHK(sw_req_handle, hnd[sw_req_port])
         gb[sw_req_port] = 0;
      end
      if (tx_v) begin
         lb[tx_port] += tx_len;
         run[tx_port] += tx_len;
         if (!tx_last) `CHK(tx_len, 128)
         if (tx_last) begin
            fq.push_back(run[tx_port]);
            run[tx_port] = 0;
         end
      end
      if (r_tx_v) begin
         rb[r_tx_port] += r_tx_len;
         if (!r_tx_last) `CHK(r_tx_len, 128)
      end
      nbuf += buf_wr_v ? int'(buf_wr_len) : 0;
      nrrel += int'(r_rel_v);
      nrel += int'(rel_v);
      nhelp += int'(helper_v);
      if (rel_v) lastrel = rel_handle;
      if (helper_v) lasthelp = helper_handle;
   end
   // No byte is driven while the block is held; valid drops and the same byte waits for release
   task automatic rx_frame(input int p, input int len);
      int i = 0;
      rem[p] = len;
      expn[p] = len;
      while (i < len) begin
         @(negedge mclk);
         rx_v[p] = !rx_hold[p];
         rx_eof[p] = (i == len - 1);
         i += int'(!rx_hold[p]);
      end
      @(negedge mclk);
      rx_v[p] = 1'b0;
   endtask
   task automatic quiet();
      int i = 0;
      idle = 0;
      while (idle < 40 && i < 5000) begin
         @(posedge mclk);
         i++;
      end
      @(negedge mclk);
   endtask
   task automatic send_rsp(input int kind);
      multi = (kind == 1 || kind == 5);
      unknown = (kind == 2);
      unres = (kind == 3);
      remote = (kind == 4);
      rsp_v = 1'b1;
      @(negedge mclk);
      rsp_v = 1'b0;
   endtask
   task automatic cmp_all();
      for (int p = 0; p < NPORT; p++) begin
         `CHK(lb[p], el[p])
         `CHK(rb[p], er[p])
         lb[p] = 0;
         rb[p] = 0;
         el[p] = 0;
         er[p] = 0;
      end
      `CHK(nrel, erel)
      `CHK(nrrel, errel)
      `CHK(nbuf, ebuf)
      `CHK(nhelp, ehelp)
      if (erel > 0) `CHK(lastrel, sh)
      if (ehelp > 0) `CHK(lasthelp, sh)
      nrel = 0;
      nrrel = 0;
      nbuf = 0;
      nhelp = 0;
   endtask
   initial begin
      tx_free = {NPORT{11'h600}};
      r_free = {NPORT{11'h600}};
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      // Kinds: local, multicast, unknown, unresolved, remote, remote multicast
      for (int i = 0; i < 12; i++) begin
         k = i % 6;
         n = (i == 0) ? 128 : (i == 1) ? 129 : 1 + rnd(700);
         src = rnd(12);
         rx_frame(src, n);
         quiet();
         sh = hnd[src];
         dp = sffe_port_type'(rnd(12));
         pri = 2'(rnd(4));
         ma = NPORT'(rnd(4096)) | NPORT'(1 << rnd(12));
         mb = NPORT'(rnd(4096));
         lm = (k == 0) ? NPORT'(1 << dp) : (k == 1) ? ma : (k == 5) ? mb : '0;
         rm = (k == 4) ? NPORT'(1 << dp) : (k == 5) ? ma : '0;
         vm = (k == 2) ? ma : mb;
         cps = CW'($countones(lm | ((k == 2) ? vm : '0)) + int'(rm != '0));
         for (int p = 0; p < NPORT; p++) begin
            el[p] = (lm[p] || (k == 2 && vm[p])) ? n : 0;
            er[p] = rm[p] ? n : 0;
         end
         erel = int'(k != 3);
         errel = int'(k == 5);
         ebuf = (k == 5) ? n : 0;
         ehelp = int'(k == 3);
         send_rsp(k);
         quiet();
         cmp_all();
      end
      // Blocked one byte short of a full frame, then released at exactly full room
      tx_free[7] = 11'h5FF;
      fq.delete();
      for (int j = 0; j < 3; j++) begin
         rx_frame(j, 200 + 100 * j);
         quiet();
         sh = hnd[j];
         dp = 4'h7;
         lm = NPORT'(1 << 7);
         rm = '0;
         cps = 5'h01;
         pri = (j == 0) ? 2'h0 : 2'h3;
         send_rsp(0);
      end
      repeat (50) @(negedge mclk);
      `CHK(lb[7], 0)
      tx_free[7] = 11'h600;
      quiet();
      `CHK(fq[0], 300)
      `CHK(fq[1], 400)
      `CHK(fq[2], 200)
      sh = hnd[0];
      el[7] = 900;
      erel = 3;
      errel = 0;
      ebuf = 0;
      ehelp = 0;
      cmp_all();
      // Several ports close one-byte blocks in the same cycle
      lp = lastp;
      gq.delete();
      ma = NPORT'(rnd(4096)) | 12'h001;
      for (int j = 1; j <= NPORT; j++) begin
         if (ma[(lp + j) % NPORT]) begin
            xq.push_back((lp + j) % NPORT);
         end
      end
      for (int p = 0; p < NPORT; p++) begin
         rem[p] = 1;
         expn[p] = 1;
      end
      rx_v = ma;
      rx_eof = ma;
      @(negedge mclk);
      rx_v = '0;
      quiet();
      `CHK(gq.size(), xq.size())
      foreach (xq[j]) `CHK(gq[j], xq[j])
      summarize();
   end
endmodule
